// ===== srcd_decoder.sv
/*
  strap resistor configuration decoder top: sequences the three strap
  readings in soft-start, classifies, decodes and latches the settings,
  and exposes them over apb.
  assumes an external measurement front end answering meas_req with
  meas_valid, and enable_ok low whenever enable or power-on is lost.
*/
`timescale 1ns/1ps
module srcd_decoder (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // power state
  input wire logic enable_ok,
  // strap measurement
  output logic meas_req,
  output logic [1:0] meas_sel,
  input wire logic meas_valid,
  input wire logic [15:0] meas_code,
  input wire logic meas_open,
  // decoded settings
  output logic config_ready,
  output logic signed [15:0] core_offset,
  output logic signed [15:0] nb_offset,
  output logic [7:0] slew_rate,
  output logic drv_to_nb,
  output logic pwm_to_nb
);

  srcd_pkg::srcd_state_e state;
  srcd_pkg::srcd_state_e next_state;
  logic [15:0] settle_cnt;
  logic [1:0] retry_cnt;
  logic [3:0] core_bin;
  logic [3:0] nb_bin;
  logic [3:0] map_bin;
  logic [3:0] cls_bin;
  logic cls_hit;
  logic signed [15:0] core_dec;
  logic signed [15:0] nb_dec;
  logic auto_start;
  logic range_err;
  logic take;
  logic last_strap;
  logic give_up;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;

  srcd_bin_classify u_cls (
    .code(meas_code),
    .open_pin(meas_open),
    .bin(cls_bin),
    .hit(cls_hit)
  );

  srcd_offset_lut #(.IS_NB(1'b0)) u_core_lut (
    .bin(core_bin),
    .offset(core_dec)
  );

  srcd_offset_lut #(.IS_NB(1'b1)) u_nb_lut (
    .bin(nb_bin),
    .offset(nb_dec)
  );

  // a reading counts once valid arrives while requested
  assign take = (state == srcd_pkg::SRCD_MEASURE) && meas_req && meas_valid;
  assign last_strap = (meas_sel == 2'd2);
  // a strap that keeps missing every window falls back to open, so
  // soft-start never hangs on a bad resistor
  assign give_up = retry_cnt == 2'(srcd_pkg::RETRY_MAX);

  always_comb begin
    next_state = state;
    case (state)
      srcd_pkg::SRCD_IDLE: begin
        if (enable_ok && auto_start) begin
          next_state = srcd_pkg::SRCD_SETTLE;
        end
      end
      srcd_pkg::SRCD_SETTLE: begin
        if (settle_cnt == 16'(srcd_pkg::SETTLE_CYC - 1)) begin
          next_state = srcd_pkg::SRCD_MEASURE;
        end
      end
      srcd_pkg::SRCD_MEASURE: begin
        if (take && (cls_hit || give_up) && last_strap) begin
          next_state = srcd_pkg::SRCD_LOCKED;
        end
      end
      srcd_pkg::SRCD_LOCKED: begin
        next_state = srcd_pkg::SRCD_LOCKED;
      end
      default: begin
        next_state = srcd_pkg::SRCD_IDLE;
      end
    endcase
    if (!enable_ok) begin
      next_state = srcd_pkg::SRCD_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= srcd_pkg::SRCD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= 16'h0000;
    end else if (state == srcd_pkg::SRCD_SETTLE) begin
      settle_cnt <= settle_cnt + 16'h0001;
    end else begin
      settle_cnt <= 16'h0000;
    end
  end

  // strap sequencing: core, nb, mapping/rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_req <= 1'b0;
      meas_sel <= 2'd0;
      retry_cnt <= 2'd0;
    end else if (next_state != srcd_pkg::SRCD_MEASURE) begin
      meas_req <= 1'b0;
      meas_sel <= 2'd0;
      retry_cnt <= 2'd0;
    end else if (state != srcd_pkg::SRCD_MEASURE) begin
      meas_req <= 1'b1;
    end else if (take) begin
      // drop the request one cycle so each reading is a fresh one
      meas_req <= 1'b0;
      if (cls_hit || give_up) begin
        meas_sel <= meas_sel + 2'd1;
        retry_cnt <= 2'd0;
      end else begin
        retry_cnt <= retry_cnt + 2'd1;
      end
    end else begin
      meas_req <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_bin <= srcd_pkg::BIN_OPEN;
      nb_bin <= srcd_pkg::BIN_OPEN;
      map_bin <= srcd_pkg::BIN_OPEN;
    end else if (take && (cls_hit || give_up)) begin
      case (meas_sel)
        2'd0: core_bin <= cls_hit ? cls_bin : srcd_pkg::BIN_OPEN;
        2'd1: nb_bin <= cls_hit ? cls_bin : srcd_pkg::BIN_OPEN;
        default: map_bin <= cls_hit ? cls_bin : srcd_pkg::BIN_OPEN;
      endcase
    end
  end

  // outputs change only on entry to locked, and clear on restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_ready <= 1'b0;
      core_offset <= 16'sh0000;
      nb_offset <= 16'sh0000;
      slew_rate <= 8'h00;
      drv_to_nb <= 1'b0;
      pwm_to_nb <= 1'b0;
    end else if (state == srcd_pkg::SRCD_IDLE) begin
      config_ready <= 1'b0;
      core_offset <= 16'sh0000;
      nb_offset <= 16'sh0000;
      slew_rate <= 8'h00;
      drv_to_nb <= 1'b0;
      pwm_to_nb <= 1'b0;
    end else if (state == srcd_pkg::SRCD_LOCKED && !config_ready) begin
      config_ready <= 1'b1;
      core_offset <= core_dec;
      nb_offset <= nb_dec;
      slew_rate <= srcd_pkg::SLEW_TAB[map_bin[1:0]];
      // one bit steers both, so they can never share a regulator
      drv_to_nb <= map_bin >= srcd_pkg::BIN_FIRST_NB_MAP;
      pwm_to_nb <= map_bin < srcd_pkg::BIN_FIRST_NB_MAP;
    end
  end

  // apb slave: zero wait states, read data captured in setup
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    case (paddr)
      srcd_pkg::CTRL_OFF,
      srcd_pkg::STATUS_OFF,
      srcd_pkg::BINS_OFF,
      srcd_pkg::CORE_OFS_OFF,
      srcd_pkg::NB_OFS_OFF,
      srcd_pkg::SLEW_MAP_OFF: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_start <= srcd_pkg::CTRL_AUTO_RST;
    end else if (wr_en && paddr == srcd_pkg::CTRL_OFF) begin
      auto_start <= pwdata[srcd_pkg::CTRL_AUTO_BIT];
    end
  end

  // sticky miss flag, write one to clear; a new miss wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      range_err <= 1'b0;
    end else if (take && !cls_hit) begin
      range_err <= 1'b1;
    end else if (wr_en && paddr == srcd_pkg::STATUS_OFF && pwdata[srcd_pkg::ST_ERR_BIT]) begin
      range_err <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= 32'h00000000;
      case (paddr)
        srcd_pkg::CTRL_OFF: prdata[srcd_pkg::CTRL_AUTO_BIT] <= auto_start;
        srcd_pkg::STATUS_OFF: begin
          prdata[2:0] <= state;
          prdata[srcd_pkg::ST_LOCKED_BIT] <= config_ready;
          prdata[srcd_pkg::ST_ERR_BIT] <= range_err;
        end
        srcd_pkg::BINS_OFF: prdata[11:0] <= {map_bin, nb_bin, core_bin};
        srcd_pkg::CORE_OFS_OFF: prdata <= 32'(core_offset);
        srcd_pkg::NB_OFS_OFF: prdata <= 32'(nb_offset);
        srcd_pkg::SLEW_MAP_OFF: begin
          prdata[7:0] <= slew_rate;
          prdata[srcd_pkg::SM_DRV_NB_BIT] <= drv_to_nb;
          prdata[srcd_pkg::SM_PWM_NB_BIT] <= pwm_to_nb;
        end
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule : srcd_decoder

// ===== srcd_pkg.sv
/*
  constants for the strap resistor configuration decoder: register map,
  tolerance bins, decode tables, timing.
  assumes a 100 mhz pclk and strap readings coded in units of 10 ohm.
*/
package srcd_pkg;

  // apb register byte offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STATUS_OFF = 12'h004;
  localparam logic [11:0] BINS_OFF = 12'h008;
  localparam logic [11:0] CORE_OFS_OFF = 12'h00c;
  localparam logic [11:0] NB_OFS_OFF = 12'h010;
  localparam logic [11:0] SLEW_MAP_OFF = 12'h014;

  // field positions
  localparam int CTRL_AUTO_BIT = 0;
  localparam int ST_LOCKED_BIT = 3;
  localparam int ST_ERR_BIT = 4;
  localparam int SM_DRV_NB_BIT = 8;
  localparam int SM_PWM_NB_BIT = 9;

  // reset values
  localparam logic CTRL_AUTO_RST = 1'b1;

  // timing: settle before the first reading
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_MAX = 3;

  // bins, window limits in 10 ohm units
  localparam logic [3:0] BIN_OPEN = 4'hf;
  localparam logic [3:0] BIN_FIRST_NB_MAP = 4'h8;
  localparam logic [15:0] OPEN_MIN = 16'h7530;
  localparam logic [15:0] BIN_MIN [0:14] = '{
    16'd554, 16'd776, 16'd1133, 16'd1665, 16'd1930, 16'd2453, 16'd3349, 16'd4058,
    16'd5152, 16'd7210, 16'd9387, 16'd11919, 16'd15169, 16'd17927, 16'd20685};
  localparam logic [15:0] BIN_MAX [0:14] = '{
    16'd570, 16'd798, 16'd1167, 16'd1715, 16'd1989, 16'd2527, 16'd3451, 16'd4181,
    16'd5308, 16'd7429, 16'd9672, 16'd12281, 16'd15631, 16'd18473, 16'd21315};

  // offsets in 10 uv units, index by bin
  localparam logic signed [15:0] CORE_OFS [0:15] = '{
    -16'sd4375, -16'sd3750, -16'sd3125, -16'sd2500, -16'sd1875, -16'sd1250,
    -16'sd625, 16'sd625, 16'sd1875, 16'sd3125, 16'sd4376, 16'sd5000,
    16'sd3750, 16'sd2500, 16'sd1250, 16'sd0};
  localparam logic signed [15:0] NB_OFS [0:15] = '{
    16'sd1875, 16'sd3125, 16'sd4376, 16'sd5000, 16'sd3750, 16'sd2500,
    16'sd1250, 16'sd0, 16'sd1875, 16'sd3125, 16'sd4376, 16'sd5000,
    16'sd3750, 16'sd2500, 16'sd1250, 16'sd0};

  // slew rate in 0.1 mv/us, index by bin modulo four
  localparam logic [7:0] SLEW_TAB [0:3] = '{8'd200, 8'd150, 8'd125, 8'd100};

  typedef enum logic [2:0] {
    SRCD_IDLE = 3'b000,
    SRCD_SETTLE = 3'b001,
    SRCD_MEASURE = 3'b010,
    SRCD_LOCKED = 3'b011
  } srcd_state_e;

endpackage : srcd_pkg

// ===== srcd_bin_classify.sv
/*
  classifies one strap reading into a tolerance bin.
  assumes the reading is already digitised and stable while valid.
*/
`timescale 1ns/1ps
module srcd_bin_classify (
  // reading
  input wire logic [15:0] code,
  input wire logic open_pin,
  // result
  output logic [3:0] bin,
  output logic hit
);

  always_comb begin
    bin = srcd_pkg::BIN_OPEN;
    hit = 1'b0;
    if (open_pin || code >= srcd_pkg::OPEN_MIN) begin
      hit = 1'b1;
    end else begin
      for (int i = 0; i < 15; i++) begin
        if (code >= srcd_pkg::BIN_MIN[i] && code <= srcd_pkg::BIN_MAX[i]) begin
          bin = 4'(i);
          hit = 1'b1;
        end
      end
    end
  end

endmodule : srcd_bin_classify

// ===== srcd_offset_lut.sv
/*
  maps an offset strap bin to a signed offset in 10 uv units.
  assumes the bin is held stable by the caller.
*/
`timescale 1ns/1ps
module srcd_offset_lut #(
  parameter bit IS_NB = 1'b0
) (
  // bin in
  input wire logic [3:0] bin,
  // offset out
  output logic signed [15:0] offset
);

  always_comb begin
    if (IS_NB) begin
      offset = srcd_pkg::NB_OFS[bin];
    end else begin
      offset = srcd_pkg::CORE_OFS[bin];
    end
  end

endmodule : srcd_offset_lut

// ===== srcd_decoder_chk.sv
/* checker for the strap decoder ports.
   assumes bind to srcd_decoder. */
`timescale 1ns/1ps
module srcd_decoder_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // straps and settings
  input wire logic enable_ok,
  input wire logic meas_req,
  input wire logic [1:0] meas_sel,
  input wire logic meas_valid,
  input wire logic config_ready,
  input wire logic signed [15:0] core_offset,
  input wire logic signed [15:0] nb_offset,
  input wire logic [7:0] slew_rate,
  input wire logic drv_to_nb,
  input wire logic pwm_to_nb
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_read_before_ready: assert property (meas_req |-> !config_ready)
    else $error("ready during strap read");
  a_read_early: assert property ($rose(enable_ok) |-> ##[1:300] meas_req)
    else $error("no strap read in soft start");
  a_req_holds: assert property (meas_req && !meas_valid && enable_ok |=>
    meas_req && $stable(meas_sel))
    else $error("request dropped early");
  a_core_range: assert property (config_ready |->
    core_offset >= -16'sd4375 && core_offset <= 16'sd5000)
    else $error("core offset out of range");
  a_nb_range: assert property (config_ready |->
    nb_offset >= 16'sd0 && nb_offset <= 16'sd5000)
    else $error("nb offset out of range");
  a_slew_legal: assert property (config_ready |->
    slew_rate inside {8'hc8, 8'h96, 8'h7d, 8'h64})
    else $error("illegal slew rate");
  a_map_apart: assert property (config_ready |-> drv_to_nb != pwm_to_nb)
    else $error("driver and pwm on one regulator");
  a_slew_locked: assert property (config_ready && $past(config_ready) |->
    $stable(slew_rate))
    else $error("slew changed while locked");
  a_held_locked: assert property (config_ready [*2] |-> $stable(core_offset) &&
    $stable(nb_offset) && $stable(drv_to_nb))
    else $error("settings changed while locked");
  a_clear_restart: assert property ($fell(enable_ok) |-> ##2 !config_ready)
    else $error("settings kept after enable loss");
endmodule : srcd_decoder_chk

bind srcd_decoder srcd_decoder_chk u_chk (.pclk, .presetn, .enable_ok, .meas_req,
  .meas_sel, .meas_valid, .config_ready, .core_offset, .nb_offset, .slew_rate,
  .drv_to_nb, .pwm_to_nb);

// ===== srcd_strap_model.sv
/* strap model: answers a read with a code inside the fitted bin, or just above it when miss is set.
   assumes requests held until taken. */
`timescale 1ns/1ps
module srcd_strap_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // reading link
  input wire logic meas_req,
  input wire logic [1:0] meas_sel,
  output logic meas_valid,
  output logic [15:0] meas_code,
  output logic meas_open,
  // fitted straps and delay
  input wire logic [3:0] bin0,
  input wire logic [3:0] bin1,
  input wire logic [3:0] bin2,
  input wire logic [1:0] dly,
  // reading lands just above its window, so every strap but an open one misses
  input wire logic miss
);
  logic [3:0] b;
  logic [1:0] cnt;
  assign b = (meas_sel == 2'h0) ? bin0 : (meas_sel == 2'h1) ? bin1 : bin2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_valid <= 1'b0;
      cnt <= 2'h0;
      meas_code <= 16'h0;
      meas_open <= 1'b0;
    end else if (!meas_req || meas_valid) begin
      // idle lines toggle so a stale value is never mistaken for data
      meas_valid <= 1'b0;
      cnt <= 2'h0;
      meas_code <= ~meas_code;
      meas_open <= ~meas_open;
    end else if (cnt == dly) begin
      meas_valid <= 1'b1;
      meas_code <= (b == 4'hf) ? 16'hffff :
        (miss ? srcd_pkg::BIN_MAX[b] + 16'h0001 : srcd_pkg::BIN_MIN[b] + 16'h0008);
      meas_open <= (b == 4'hf);
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule : srcd_strap_model

// ===== srcd_decoder_test.sv
/* random and corner strap sets, restarts, apb reads.
   assumes checker and strap model alongside. */
`timescale 1ns/1ps
module srcd_decoder_test;
  logic pclk, presetn, psel, penable, pwrite, enable_ok, er, miss;
  logic pready, pslverr, meas_req, meas_valid, meas_open;
  logic config_ready, drv_to_nb, pwm_to_nb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] meas_sel, dly;
  logic [15:0] meas_code;
  logic signed [15:0] core_offset, nb_offset;
  logic [7:0] slew_rate;
  logic [3:0] bin0, bin1, bin2;
  int bad_count, n_checks, seed, cyc, i;
  logic signed [15:0] ec [16] = '{-4375, -3750, -3125, -2500, -1875, -1250, -625, 625,
    1875, 3125, 4376, 5000, 3750, 2500, 1250, 0};
  logic signed [15:0] en [16] = '{1875, 3125, 4376, 5000, 3750, 2500, 1250, 0,
    1875, 3125, 4376, 5000, 3750, 2500, 1250, 0};
  srcd_decoder u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .enable_ok, .meas_req, .meas_sel, .meas_valid,
    .meas_code, .meas_open, .config_ready, .core_offset, .nb_offset, .slew_rate,
    .drv_to_nb, .pwm_to_nb);
  srcd_strap_model u_strap (.pclk, .presetn, .meas_req, .meas_sel, .meas_valid,
    .meas_code, .meas_open, .bin0, .bin1, .bin2, .dly, .miss);
  function automatic logic [7:0] slew_of(input logic [3:0] b);
    return (b[1:0] == 2'h0) ? 8'hc8 : (b[1:0] == 2'h1) ? 8'h96 :
      (b[1:0] == 2'h2) ? 8'h7d : 8'h64;
  endfunction : slew_of
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run(input logic [3:0] c, input logic [3:0] n, input logic [3:0] m);
    enable_ok <= 1'b0;
    repeat (4) @(posedge pclk);
    bin0 <= c;
    bin1 <= n;
    bin2 <= m;
    dly <= 2'($random(seed));
    // straps that miss every window give up and read as open
    if (miss) {c, n, m} = 12'hfff;
    enable_ok <= 1'b1;
    for (i = 0; i < 1000 && config_ready !== 1'b1; i++) @(posedge pclk);
    chk(16'(config_ready), 16'h1);
    // second pass runs after the straps moved under a locked setting
    repeat (2) begin
      chk(core_offset, ec[c]);
      chk(nb_offset, en[n]);
      chk(16'(slew_rate), 16'(slew_of(m)));
      chk(16'(drv_to_nb), 16'(m >= 4'h8));
      chk(16'(pwm_to_nb), 16'(m < 4'h8));
      bin0 <= ~c;
      bin1 <= ~n;
      bin2 <= m ^ 4'h5;
      repeat (30) @(posedge pclk);
    end
    apb(1'b0, srcd_pkg::SLEW_MAP_OFF, 32'h0);
    chk(rd[15:0], {6'h0, m < 4'h8, m >= 4'h8, slew_of(m)});
    apb(1'b0, srcd_pkg::BINS_OFF, 32'h0);
    chk(rd[15:0], {4'h0, m, n, c});
    apb(1'b0, srcd_pkg::CORE_OFS_OFF, 32'h0);
    chk(rd[15:0], ec[c]);
    chk(rd[31:16], {16{ec[c][15]}});
    apb(1'b0, srcd_pkg::NB_OFS_OFF, 32'h0);
    chk(rd[15:0], en[n]);
    chk(rd[31:16], 16'h0000);
    apb(1'b0, srcd_pkg::STATUS_OFF, 32'h0);
    chk(rd[15:0], {11'h000, miss, 4'hb});
    apb(1'b1, srcd_pkg::STATUS_OFF, 32'h10);
    apb(1'b0, srcd_pkg::STATUS_OFF, 32'h0);
    chk(rd[15:0], 16'h000b);
    $display("test done, straps %h %h %h", c, n, m);
  endtask : run
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test;
    end
  end
  initial begin
    seed = 32'h39c7;
    {psel, penable, pwrite, enable_ok, presetn} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    {bin0, bin1, bin2, dly, miss} = 15'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, srcd_pkg::CTRL_OFF, 32'h0);
    chk(rd[15:0], 16'(srcd_pkg::CTRL_AUTO_RST));
    apb(1'b0, 12'h0f0, 32'h0);
    chk(16'(er), 16'h1);
    // auto start off: enable alone must not start sampling
    apb(1'b1, srcd_pkg::CTRL_OFF, 32'h0);
    enable_ok <= 1'b1;
    repeat (50) @(posedge pclk);
    apb(1'b0, srcd_pkg::STATUS_OFF, 32'h0);
    chk(rd[15:0], 16'h0000);
    apb(1'b1, srcd_pkg::CTRL_OFF, 32'h1);
    repeat (250) @(posedge pclk);
    chk(16'(config_ready), 16'h1);
    run(4'h0, 4'h0, 4'h7);
    run(4'hf, 4'hf, 4'h8);
    run(4'h7, 4'h7, 4'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(16'(config_ready), 16'h0);
    presetn <= 1'b1;
    run(4'he, 4'h8, 4'hf);
    miss <= 1'b1;
    run(4'h3, 4'h9, 4'he);
    miss <= 1'b0;
    for (int k = 0; k < 12; k++) run(4'($random(seed)), 4'($random(seed)), 4'($random(seed)));
    finish_test;
  end
endmodule : srcd_decoder_test
